// >>> rtl/dtds_seq.sv
// dma channel direction sequencer with ahb-lite registers and 8 kbyte staging buffer
`timescale 1ns/1ps
`include "dtds_params.svh"

module dtds_seq #(
    parameter int BUF_BYTES = `DTDS_BUF_BYTES,
    parameter int DW        = `DTDS_DATA_W
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    // ahb-lite register slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // interrupt
    output logic                     irq,
    // read request to linkage
    output logic                     rd_req_valid,
    input  wire logic                rd_req_ready,
    output logic                     rd_req_bus,
    output logic [31:0]              rd_req_addr,
    output dtds_pkg::dtds_size_t     rd_req_size,
    // read data from linkage
    input  wire logic                rd_data_valid,
    output logic                     rd_data_ready,
    input  wire logic [DW-1:0]       rd_data,
    // write request to linkage
    output logic                     wr_req_valid,
    input  wire logic                wr_req_ready,
    output logic                     wr_req_bus,
    output logic [31:0]              wr_req_addr,
    output dtds_pkg::dtds_size_t     wr_req_size,
    // write data to linkage
    output logic                     wr_data_valid,
    input  wire logic                wr_data_ready,
    output logic [DW-1:0]            wr_data
);
    import dtds_pkg::*;

    localparam int WB    = DW / 8;
    localparam int SH    = $clog2(WB);
    localparam int DEPTH = BUF_BYTES / WB;
    localparam int AW    = $clog2(DEPTH);
    localparam int CW    = AW + 1;
    localparam int AVW   = CW + SH;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    function automatic dtds_size_t blk_bytes(input logic [2:0] code);
        return `DTDS_BLK_MIN_BYTES << code;
    endfunction

    function automatic logic [CW-1:0] words_of(input dtds_size_t bytes);
        dtds_size_t t;
        t = bytes + 13'(WB - 1);
        return CW'(t >> SH);
    endfunction

    function automatic dtds_size_t lim(input dtds_size_t a, input dtds_count_t b);
        return (b < 33'(a)) ? b[12:0] : a;
    endfunction

    // lanes are bytes or 32-bit words; increment runs across lanes
    function automatic logic [DW-1:0] pat_word(input logic [31:0] p, input logic is32,
                                               input logic inc);
        logic [DW-1:0] w;
        w = '0;
        if (is32) begin
            for (int i = 0; i < DW / 32; i++) begin
                w[i*32 +: 32] = p + (inc ? 32'(i) : 32'h0);
            end
        end else begin
            for (int i = 0; i < WB; i++) begin
                w[i*8 +: 8] = p[7:0] + (inc ? 8'(i) : 8'h0);
            end
        end
        return w;
    endfunction

    // register file
    logic [31:0]       ctrl_ff;
    logic [31:0]       src_addr_ff;
    logic [31:0]       dst_addr_ff;
    logic [31:0]       cnt_ff;
    logic [31:0]       pat_cfg_ff;
    logic [CW-1:0]     thr_ff;
    logic [1:0]        imask_ff;
    logic [1:0]        istat_ff;
    logic [1:0]        nxt_istat;
    // ahb data phase
    logic              dph_v_ff;
    logic              dph_w_ff;
    logic [7:0]        dph_a_ff;
    // channel state
    dtds_state_t       state_ff;
    dtds_state_t       nxt_state;
    logic [31:0]       run_ctrl_ff;
    logic [31:0]       rd_addr_ff;
    logic [31:0]       wr_addr_ff;
    dtds_count_t       rd_left_ff;
    dtds_count_t       rcv_left_ff;
    dtds_count_t       wr_left_ff;
    logic [AVW-1:0]    avail_ff;
    logic [31:0]       pat_ff;
    // staging buffer
    logic [DW-1:0]     mem [DEPTH];
    logic [AW-1:0]     wptr_ff;
    logic [AW-1:0]     rptr_ff;
    logic [CW-1:0]     used_ff;
    logic [CW-1:0]     resv_ff;
    logic [CW-1:0]     wd_left_ff;
    // request holding registers
    logic              rreq_v_ff;
    dtds_size_t        rreq_sz_ff;
    logic [31:0]       rreq_addr_ff;
    logic              wreq_v_ff;
    dtds_size_t        wreq_sz_ff;
    logic [31:0]       wreq_addr_ff;

    // ahb decode; zero wait, always okay, unmapped reads zero and writes drop
    wire ap_take  = hsel & htrans[1] & hready;
    wire bus_wr   = dph_v_ff & dph_w_ff;
    wire bus_rd   = dph_v_ff & ~dph_w_ff;
    wire wr_ctrl  = bus_wr & hit(dph_a_ff, `DTDS_OFF_CTRL);
    wire wr_src   = bus_wr & hit(dph_a_ff, `DTDS_OFF_SRC);
    wire wr_dst   = bus_wr & hit(dph_a_ff, `DTDS_OFF_DST);
    wire wr_cnt   = bus_wr & hit(dph_a_ff, `DTDS_OFF_CNT);
    wire wr_pat   = bus_wr & hit(dph_a_ff, `DTDS_OFF_PAT);
    wire wr_thr   = bus_wr & hit(dph_a_ff, `DTDS_OFF_THR);
    wire wr_imask = bus_wr & hit(dph_a_ff, `DTDS_OFF_IMASK);
    wire rd_istat = bus_rd & hit(dph_a_ff, `DTDS_OFF_ISTAT);

    wire busy     = state_ff != ST_IDLE;
    wire go_wr    = wr_ctrl & hwdata[`DTDS_CTRL_GO];
    wire go_start = go_wr & ~busy;
    wire go_rej   = go_wr & busy;

    // setup except the threshold is latched at go, so later register writes other than THR do not disturb a run
    wire [31:0]   go_ctrl  = hwdata & `DTDS_CTRL_MASK;
    wire [1:0]    go_src   = go_ctrl[`DTDS_CTRL_SRC_LSB +: 2];
    wire          go_same  = ~go_src[1] & (go_src[0] == go_ctrl[`DTDS_CTRL_DST]);
    wire dtds_count_t len  = (cnt_ff == 32'h0) ? `DTDS_FULL_LEN : {1'b0, cnt_ff};

    // path decode of the running transfer
    wire [1:0]    run_src  = run_ctrl_ff[`DTDS_CTRL_SRC_LSB +: 2];
    wire          run_dst  = run_ctrl_ff[`DTDS_CTRL_DST];
    wire          src_pat  = run_src[1];
    wire [2:0]    pblk     = run_ctrl_ff[`DTDS_CTRL_PBLK_LSB +: 3];
    wire [2:0]    vblk     = run_ctrl_ff[`DTDS_CTRL_VBLK_LSB +: 3];
    wire          pat_inc  = run_ctrl_ff[`DTDS_CTRL_PAT_INC];
    wire          pat_32   = run_ctrl_ff[`DTDS_CTRL_PAT_32];
    wire dtds_size_t rd_blk = blk_bytes(run_src[0] ? vblk : pblk);
    wire dtds_size_t wr_blk = blk_bytes(run_dst ? vblk : pblk);

    // read side
    wire [CW-1:0] free_w   = CW'(DEPTH) - resv_ff;
    wire dtds_size_t rd_sz = lim(rd_blk, rd_left_ff);
    wire          rd_space = free_w >= words_of(rd_sz);
    wire          rd_phase = (state_ff == ST_FILL) | (state_ff == ST_STREAM);
    wire          rd_issue = rd_phase & ~src_pat & ~rreq_v_ff
                             & (rd_left_ff != 33'h0) & rd_space;
    wire          pat_push = rd_phase & src_pat & (rcv_left_ff != 33'h0)
                             & (free_w != '0);
    // only data already given space is taken, so the master's queue holds the rest
    assign rd_data_ready = busy & ~src_pat & (resv_ff != used_ff);
    wire          rd_push  = rd_data_valid & rd_data_ready;
    wire          push     = rd_push | pat_push;
    wire [DW-1:0] push_dat = src_pat ? pat_word(pat_ff, pat_32, pat_inc) : rd_data;
    wire [SH:0]   push_b   = (rcv_left_ff >= 33'(WB)) ? (SH+1)'(WB) : rcv_left_ff[SH:0];
    wire [31:0]   pat_step = pat_inc ? (pat_32 ? 32'(DW / 32) : 32'(WB)) : 32'h0;

    // write side
    wire dtds_size_t wr_sza = lim(wr_blk, wr_left_ff);
    wire dtds_size_t wr_sz  = (avail_ff < AVW'(wr_sza)) ? avail_ff[12:0] : wr_sza;
    wire          wr_phase = (state_ff == ST_DRAIN) | (state_ff == ST_STREAM);
    // streaming waits for a whole block to avoid splintering the destination bus
    wire          wr_have  = (state_ff == ST_DRAIN) ? (avail_ff != '0)
                                                    : (avail_ff >= AVW'(wr_sza));
    wire          wr_issue = wr_phase & ~wreq_v_ff & (wr_left_ff != 33'h0)
                             & wr_have;
    assign wr_data_valid = (wd_left_ff != '0) & (used_ff != '0);
    wire          pop      = wr_data_valid & wr_data_ready;

    // sequencing
    wire          all_in   = resv_ff == used_ff;
    wire          wr_idle  = (wd_left_ff == '0) & ~wreq_v_ff;
    wire          fin      = (wr_left_ff == 33'h0) & wr_idle;
    wire          to_drain = all_in & ~rreq_v_ff & ((used_ff >= thr_ff)
                             | (rd_left_ff == 33'h0) | ~rd_space);
    wire          to_fill  = (used_ff == '0) & wr_idle & (avail_ff == '0);
    wire          done_ev  = wr_phase & fin;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (go_start) begin
                    nxt_state = go_same ? ST_FILL : ST_STREAM;
                end
            end
            ST_FILL: begin
                if (to_drain) begin
                    nxt_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (fin) begin
                    nxt_state = ST_IDLE;
                end else if (to_fill) begin
                    nxt_state = ST_FILL;
                end
            end
            ST_STREAM: begin
                if (fin) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // set wins over the read clear
    assign nxt_istat = (istat_ff & ~{2{rd_istat}})
                       | {go_rej, done_ev};

    // register read mux
    wire [31:0] stat_v = {30'h0, istat_ff[`DTDS_INT_DONE], busy};
    wire [31:0] rd_mux =
        hit(dph_a_ff, `DTDS_OFF_CTRL)  ? ctrl_ff :
        hit(dph_a_ff, `DTDS_OFF_SRC)   ? src_addr_ff :
        hit(dph_a_ff, `DTDS_OFF_DST)   ? dst_addr_ff :
        hit(dph_a_ff, `DTDS_OFF_CNT)   ? cnt_ff :
        hit(dph_a_ff, `DTDS_OFF_PAT)   ? pat_cfg_ff :
        hit(dph_a_ff, `DTDS_OFF_THR)   ? 32'(thr_ff) :
        hit(dph_a_ff, `DTDS_OFF_STAT)  ? stat_v :
        hit(dph_a_ff, `DTDS_OFF_REM)   ? wr_left_ff[31:0] :
        hit(dph_a_ff, `DTDS_OFF_ISTAT) ? {30'h0, istat_ff} :
        hit(dph_a_ff, `DTDS_OFF_IMASK) ? {30'h0, imask_ff} : 32'h0;

    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = bus_rd ? rd_mux : 32'h0;
    assign irq           = |(istat_ff & imask_ff);
    assign rd_req_valid  = rreq_v_ff;
    assign rd_req_bus    = run_src[0];
    assign rd_req_addr   = rreq_addr_ff;
    assign rd_req_size   = rreq_sz_ff;
    assign wr_req_valid  = wreq_v_ff;
    assign wr_req_bus    = run_dst;
    assign wr_req_addr   = wreq_addr_ff;
    assign wr_req_size   = wreq_sz_ff;
    assign wr_data       = mem[rptr_ff];

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dph_v_ff <= 1'b0;
            dph_w_ff <= 1'b0;
            dph_a_ff <= 8'h00;
        end else begin
            dph_v_ff <= ap_take;
            dph_w_ff <= hwrite;
            dph_a_ff <= haddr[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff     <= `DTDS_CTRL_RST;
            src_addr_ff <= 32'h0;
            dst_addr_ff <= 32'h0;
            cnt_ff      <= 32'h0;
            pat_cfg_ff  <= 32'h0;
            thr_ff      <= `DTDS_THR_RST;
            imask_ff    <= `DTDS_IMASK_RST;
            istat_ff    <= 2'h0;
        end else begin
            ctrl_ff     <= wr_ctrl ? go_ctrl : ctrl_ff;
            src_addr_ff <= wr_src ? hwdata : src_addr_ff;
            dst_addr_ff <= wr_dst ? hwdata : dst_addr_ff;
            cnt_ff      <= wr_cnt ? hwdata : cnt_ff;
            pat_cfg_ff  <= wr_pat ? hwdata : pat_cfg_ff;
            thr_ff      <= wr_thr ? hwdata[CW-1:0] : thr_ff;
            imask_ff    <= wr_imask ? hwdata[1:0] : imask_ff;
            istat_ff    <= nxt_istat;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff    <= ST_IDLE;
            run_ctrl_ff <= `DTDS_CTRL_RST;
            rd_addr_ff  <= 32'h0;
            wr_addr_ff  <= 32'h0;
            pat_ff      <= 32'h0;
        end else begin
            state_ff    <= nxt_state;
            run_ctrl_ff <= go_start ? go_ctrl : run_ctrl_ff;
            rd_addr_ff  <= go_start ? src_addr_ff
                         : rd_issue ? rd_addr_ff + 32'(rd_sz) : rd_addr_ff;
            wr_addr_ff  <= go_start ? dst_addr_ff
                         : wr_issue ? wr_addr_ff + 32'(wr_sz) : wr_addr_ff;
            pat_ff      <= go_start ? pat_cfg_ff
                         : pat_push ? pat_ff + pat_step : pat_ff;
        end
    end

    // byte accounting: requested, received, offered to the destination
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_left_ff  <= 33'h0;
            rcv_left_ff <= 33'h0;
            wr_left_ff  <= 33'h0;
            avail_ff    <= '0;
        end else begin
            rd_left_ff  <= go_start ? len
                         : rd_issue ? rd_left_ff - 33'(rd_sz) : rd_left_ff;
            rcv_left_ff <= go_start ? len
                         : push ? rcv_left_ff - 33'(push_b) : rcv_left_ff;
            wr_left_ff  <= go_start ? len
                         : wr_issue ? wr_left_ff - 33'(wr_sz) : wr_left_ff;
            avail_ff    <= go_start ? '0
                         : avail_ff + (push ? AVW'(push_b) : '0)
                           - (wr_issue ? AVW'(wr_sz) : '0);
        end
    end

    // buffer occupancy; reserved space covers reads still in flight
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wptr_ff    <= '0;
            rptr_ff    <= '0;
            used_ff    <= '0;
            resv_ff    <= '0;
            wd_left_ff <= '0;
        end else begin
            wptr_ff    <= push ? wptr_ff + AW'(1) : wptr_ff;
            rptr_ff    <= pop ? rptr_ff + AW'(1) : rptr_ff;
            used_ff    <= used_ff + CW'(push) - CW'(pop);
            resv_ff    <= resv_ff + (rd_issue ? words_of(rd_sz) : CW'(pat_push))
                          - CW'(pop);
            wd_left_ff <= wd_left_ff + (wr_issue ? words_of(wr_sz) : '0) - CW'(pop);
        end
    end

    // storage has no reset; occupancy counters guard every read
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wptr_ff] <= push_dat;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rreq_v_ff    <= 1'b0;
            rreq_sz_ff   <= '0;
            rreq_addr_ff <= 32'h0;
        end else begin
            rreq_v_ff    <= rd_issue | (rreq_v_ff & ~rd_req_ready);
            rreq_sz_ff   <= rd_issue ? rd_sz : rreq_sz_ff;
            rreq_addr_ff <= rd_issue ? rd_addr_ff : rreq_addr_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wreq_v_ff    <= 1'b0;
            wreq_sz_ff   <= '0;
            wreq_addr_ff <= 32'h0;
        end else begin
            wreq_v_ff    <= wr_issue | (wreq_v_ff & ~wr_req_ready);
            wreq_sz_ff   <= wr_issue ? wr_sz : wreq_sz_ff;
            wreq_addr_ff <= wr_issue ? wr_addr_ff : wreq_addr_ff;
        end
    end

endmodule

// >>> rtl/dtds_params.svh
// offsets, field positions, reset values and sizes of the transfer sequencer
`ifndef DTDS_PARAMS_SVH
`define DTDS_PARAMS_SVH
`define DTDS_OFF_CTRL      8'h00
`define DTDS_OFF_SRC       8'h04
`define DTDS_OFF_DST       8'h08
`define DTDS_OFF_CNT       8'h0C
`define DTDS_OFF_PAT       8'h10
`define DTDS_OFF_THR       8'h14
`define DTDS_OFF_STAT      8'h18
`define DTDS_OFF_REM       8'h1C
`define DTDS_OFF_ISTAT     8'h20
`define DTDS_OFF_IMASK     8'h24
`define DTDS_CTRL_GO       0
`define DTDS_CTRL_SRC_LSB  1
`define DTDS_CTRL_DST      3
`define DTDS_CTRL_PBLK_LSB 4
`define DTDS_CTRL_VBLK_LSB 8
`define DTDS_CTRL_PAT_INC  12
`define DTDS_CTRL_PAT_32   13
`define DTDS_CTRL_MASK     32'h0000_3F7E
`define DTDS_SRC_PCIX      2'h0
`define DTDS_SRC_VME       2'h1
`define DTDS_SRC_PAT       2'h2
`define DTDS_BUS_PCIX      1'h0
`define DTDS_BUS_VME       1'h1
`define DTDS_BLK_MIN_BYTES 13'h0020
`define DTDS_INT_DONE      0
`define DTDS_INT_GOREJ     1
`define DTDS_CTRL_RST      32'h0000_0000
`define DTDS_THR_RST       11'h200
`define DTDS_IMASK_RST     2'h0
`define DTDS_FULL_LEN      33'h1_0000_0000
`define DTDS_BUF_BYTES     8192
`define DTDS_DATA_W        64
`endif

// >>> rtl/dtds_pkg.sv
// types shared by the transfer sequencer
package dtds_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_DRAIN, ST_STREAM} dtds_state_t;
    typedef logic [12:0] dtds_size_t;
    typedef logic [32:0] dtds_count_t;
endpackage

// >>> tb/dtds_link_model.sv
// linkage partner model: takes requests, streams read data, sinks write data
`timescale 1ns/1ps
module dtds_link_model (
    // clock, reset, pacing
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    input  wire logic                 slow,
    // read side
    input  wire logic                 rd_req_valid,
    output logic                      rd_req_ready,
    input  wire dtds_pkg::dtds_size_t rd_req_size,
    output logic                      rd_data_valid,
    input  wire logic                 rd_data_ready,
    output logic [63:0]               rd_data,
    // write side
    output logic                      wr_req_ready,
    output logic                      wr_data_ready
);
    logic [31:0] pend_ff;
    logic [31:0] seq_ff;
    logic [1:0]  cyc_ff;
    logic        take;
    logic        pop;
    // slow mode stalls requests three cycles in four and data two cycles in four, as a busy arbiter would
    assign rd_req_ready  = !slow || cyc_ff == 2'h1;
    assign wr_req_ready  = !slow || cyc_ff == 2'h2;
    assign wr_data_ready = !slow || cyc_ff[0];
    assign rd_data_valid = pend_ff != 32'h0 && (!slow || cyc_ff[1]);
    // idle data bus shows the inverse so stale words never look valid
    assign rd_data = rd_data_valid ? {32'hA5A5_0000, seq_ff} : ~{32'hA5A5_0000, seq_ff};
    assign take = rd_req_valid && rd_req_ready;
    assign pop  = rd_data_valid && rd_data_ready;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_ff <= 32'h0;
            seq_ff  <= 32'h0;
            cyc_ff  <= 2'h0;
        end else begin
            cyc_ff  <= cyc_ff + 2'h1;
            pend_ff <= pend_ff + (take ? 32'((rd_req_size + 13'h7) >> 3) : 32'h0) - 32'(pop);
            seq_ff  <= seq_ff + 32'(pop);
        end
    end
endmodule

// >>> tb/dtds_seq_assertions.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module dtds_seq_assertions (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        irq,
    // linkage
    input  wire logic        rd_req_valid,
    input  wire logic        rd_req_ready,
    input  wire logic        rd_req_bus,
    input  wire logic [31:0] rd_req_addr,
    input  wire logic [12:0] rd_req_size,
    input  wire logic        rd_data_ready,
    input  wire logic        wr_req_valid,
    input  wire logic        wr_req_ready,
    input  wire logic        wr_req_bus,
    input  wire logic        wr_data_valid,
    input  wire logic        wr_data_ready,
    input  wire logic [63:0] wr_data
);
    logic        ctl_pend_ff;
    logic [31:0] ctl_ff;
    wire  [12:0] blk_max = 13'h20 << (rd_req_bus ? ctl_ff[10:8] : ctl_ff[6:4]);
    // shadow of the control word, written in the data phase
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_pend_ff <= 1'b0;
            ctl_ff      <= 32'h0;
        end else begin
            ctl_pend_ff <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
            if (ctl_pend_ff)
                ctl_ff <= hwdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence rd_wait; rd_req_valid && !rd_req_ready; endsequence
    sequence rd_take; rd_req_valid && rd_req_ready; endsequence
    sequence wr_wait; wr_req_valid && !wr_req_ready; endsequence
    sequence wr_take; wr_req_valid && wr_req_ready; endsequence
    a_rd_req_hold: assert property (rd_wait |=> rd_req_valid && $stable(rd_req_addr)
        && $stable(rd_req_size) && $stable(rd_req_bus)) else $error("read request moved");
    a_wr_req_hold: assert property (wr_wait |=> wr_req_valid && $stable(wr_req_bus))
        else $error("write request moved");
    a_rd_gap_after: assert property (rd_take |=> !rd_req_valid)
        else $error("read request not dropped after acceptance");
    a_wr_gap_after: assert property (wr_take |=> !wr_req_valid)
        else $error("write request not dropped after acceptance");
    a_rd_size_limit: assert property (rd_req_valid |-> rd_req_size != 13'h0
        && rd_req_size <= blk_max) else $error("read size beyond block size");
    a_rd_src_bus: assert property (rd_req_valid |-> rd_req_bus == ctl_ff[1])
        else $error("read request on wrong bus");
    a_wr_dst_bus: assert property (wr_req_valid |-> wr_req_bus == ctl_ff[3])
        else $error("write request on wrong bus");
    a_pattern_no_read: assert property (rd_req_valid || rd_data_ready |-> !ctl_ff[2])
        else $error("pattern run used the read side");
    a_wr_data_hold: assert property (wr_data_valid && !wr_data_ready
        |=> wr_data_valid && $stable(wr_data)) else $error("write word dropped or changed");
    a_irq_reset_low: assert property ($rose(arst_n) |-> !irq)
        else $error("interrupt high after reset");
endmodule
bind dtds_seq dtds_seq_assertions u_chk (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .irq, .rd_req_valid, .rd_req_ready, .rd_req_bus, .rd_req_addr,
    .rd_req_size, .rd_data_ready, .wr_req_valid, .wr_req_ready, .wr_req_bus, .wr_data_valid,
    .wr_data_ready, .wr_data);

// >>> tb/dtds_transfer_direction_sequencer_test.sv
// testbench: register bus tasks and the six transfer paths
`timescale 1ns/1ps
`include "dtds_params.svh"
module dtds_transfer_direction_sequencer_test;
    import dtds_pkg::*;
    logic ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire logic hreadyout, hresp, irq, rd_req_valid, rd_req_ready, rd_req_bus, rd_data_valid;
    wire logic rd_data_ready, wr_req_valid, wr_req_ready, wr_req_bus, wr_data_valid;
    wire logic wr_data_ready;
    wire logic [31:0] hrdata, rd_req_addr, wr_req_addr;
    wire dtds_size_t rd_req_size, wr_req_size;
    wire logic [63:0] rd_data, wr_data;
    wire logic hready = hreadyout;
    int fail_count = 0, checks = 0, wr_words = 0, rd_reqs = 0;
    logic [63:0] first_rd, first_wr;
    logic got_rd, got_wr, rd_bus, wr_bus;
    logic [31:0] rd_end, wr_end;
    dtds_seq uut (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .irq, .rd_req_valid, .rd_req_ready, .rd_req_bus,
        .rd_req_addr, .rd_req_size, .rd_data_valid, .rd_data_ready, .rd_data, .wr_req_valid,
        .wr_req_ready, .wr_req_bus, .wr_req_addr, .wr_req_size, .wr_data_valid,
        .wr_data_ready, .wr_data);
    dtds_link_model link (.ref_clk, .arst_n, .slow, .rd_req_valid, .rd_req_ready, .rd_req_size,
        .rd_data_valid, .rd_data_ready, .rd_data, .wr_req_ready, .wr_data_ready);
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (rd_data_valid && rd_data_ready && !got_rd) begin
            first_rd = rd_data;
            got_rd = 1'b1;
        end
        if (wr_data_valid && wr_data_ready) begin
            wr_words++;
            if (!got_wr) first_wr = wr_data;
            got_wr = 1'b1;
        end
        if (rd_req_valid && rd_req_ready) begin
            rd_reqs++;
            rd_bus = rd_req_bus;
            rd_end = rd_req_addr + 32'(rd_req_size);
        end
        if (wr_req_valid && wr_req_ready) begin
            wr_bus = wr_req_bus;
            wr_end = wr_req_addr + 32'(wr_req_size);
        end
    end
    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one phase: hold until hready is seen high at an edge, data taken from before that edge
    task automatic phase(output logic [31:0] q);
        int n;
        logic r;
        n = 0;
        do begin
            @(negedge ref_clk);
            q = hrdata;
            r = hreadyout;
            @(posedge ref_clk);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) begin
            fail_count++;
            complete_run();
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        phase(q);
        htrans <= 2'h0;
        hwdata <= d;
        phase(q);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        check(64'(q), 64'(exp));
        check(64'(hresp), 64'h0);
    endtask
    task automatic run(input logic [1:0] src, input logic dst, input logic [31:0] cnt,
                       input logic slw, input logic rej);
        logic [31:0] ctl;
        int n;
        ctl = {18'h0, {2{&src}}, 1'b0, 3'h2, 1'b0, 3'h1, dst, src, 1'b0};
        slow <= slw;
        got_rd = 1'b0;
        got_wr = 1'b0;
        wr_words = 0;
        rd_reqs = 0;
        wreg(`DTDS_OFF_SRC, 32'h1000);
        wreg(`DTDS_OFF_DST, 32'h8000);
        wreg(`DTDS_OFF_CNT, cnt);
        wreg(`DTDS_OFF_PAT, 32'h20);
        wreg(`DTDS_OFF_IMASK, 32'h1);
        wreg(`DTDS_OFF_CTRL, ctl | 32'h1);
        if (rej) wreg(`DTDS_OFF_CTRL, ctl | 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        check(64'(n < 20000), 64'h1);
        if (n >= 20000) complete_run();
        check(64'(wr_words), 64'((cnt + 32'h7) >> 3));
        check(64'(rd_reqs != 0), 64'(src < 2'h2));
        if (src < 2'h2) check(first_wr, first_rd);
        else check(first_wr, &src ? 64'h21_0000_0020 : 64'h2020_2020_2020_2020);
        if (src < 2'h2) check(64'(rd_bus), 64'(src[0]));
        check(64'(wr_bus), 64'(dst));
        check(64'(wr_end), 64'(32'h8000 + cnt));
        if (src < 2'h2) check(64'(rd_end), 64'(32'h1000 + cnt));
        rchk(`DTDS_OFF_REM, 32'h0);
        rchk(`DTDS_OFF_ISTAT, rej ? 32'h3 : 32'h1);
        rchk(`DTDS_OFF_ISTAT, 32'h0);
        check(64'(irq), 64'h0);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rchk(`DTDS_OFF_CTRL, `DTDS_CTRL_RST);
        rchk(`DTDS_OFF_THR, 32'(`DTDS_THR_RST));
        rchk(`DTDS_OFF_IMASK, 32'h0);
        rchk(`DTDS_OFF_STAT, 32'h0);
        wreg(8'h30, 32'hFFFF_FFFF);
        rchk(8'h30, 32'h0);
        // larger than the staging buffer, so streaming reads have to stall on space
        run(`DTDS_SRC_PCIX, `DTDS_BUS_VME, 32'h4000, 1'b0, 1'b1);
        run(`DTDS_SRC_VME, `DTDS_BUS_PCIX, 32'h4000, 1'b1, 1'b0);
        run(`DTDS_SRC_PCIX, `DTDS_BUS_PCIX, 32'hBB8, 1'b0, 1'b0);
        // past the threshold and exactly the staging buffer's size, so one fill takes it all before a single drain
        run(`DTDS_SRC_VME, `DTDS_BUS_VME, 32'h2000, 1'b1, 1'b0);
        run(`DTDS_SRC_PAT, `DTDS_BUS_VME, 32'h64, 1'b0, 1'b0);
        run(2'h3, `DTDS_BUS_PCIX, 32'h1, 1'b1, 1'b0);
        complete_run();
    end
endmodule
